/* File: common/ipl_defines.svh */
// ipl_defines: offsets, field positions, masks and reset values
// assumes inclusion by the package and the design files by bare name
`ifndef IPL_DEFINES_SVH
`define IPL_DEFINES_SVH

// register indices, byte address is four times the index
`define IPL_IDX_DBG      10'h001
`define IPL_IDX_FLASH    10'h002
`define IPL_IDX_PORT     10'h003
`define IPL_ADDR_W       12

// reset values
`define IPL_RST_DBG      16'h0000
`define IPL_RST_FLASH    16'h0000
`define IPL_RST_PORT     16'h0000

// writable bits, the rest are reserved
`define IPL_WMASK_DBG    16'h003f
`define IPL_WMASK_FLASH  16'hffcf
`define IPL_WMASK_PORT   16'hfffc

// source counts
`define IPL_SRC_N        17
`define IPL_DBG_N        3

// field low-bit positions, debug register
`define IPL_POS_DBG_RX   4
`define IPL_POS_DBG_TX   2
`define IPL_POS_DBG_TRC  0
// field low-bit positions, flash, clock and pin register
`define IPL_POS_FL_EMPTY 14
`define IPL_POS_FL_DONE  12
`define IPL_POS_FL_ERR   10
`define IPL_POS_PLL      8
`define IPL_POS_LVD      6
`define IPL_POS_PIN_B    2
`define IPL_POS_PIN_A    0
// field low-bit positions, port and can register
`define IPL_POS_PORT_D   14
`define IPL_POS_PORT_E   12
`define IPL_POS_PORT_F   10
`define IPL_POS_CAN_MSG  8
`define IPL_POS_CAN_WAKE 6
`define IPL_POS_CAN_ERR  4
`define IPL_POS_CAN_BOFF 2

`endif

/* File: common/ipl_pkg.sv */
// ipl_pkg: types shared by the priority level register block
// assumes ipl_defines.svh is on the include path
`include "ipl_defines.svh"

package ipl_pkg;

   // decoded level of one source
   typedef struct packed {
      logic       en;
      logic [1:0] level;
   } ipl_src_t;

   // apb request from the master
   typedef struct packed {
      logic                   psel;
      logic                   penable;
      logic                   pwrite;
      logic [`IPL_ADDR_W-1:0] paddr;
      logic [31:0]            pwdata;
      logic [3:0]             pstrb;
   } ipl_apb_req_t;

   // apb answer from the slave
   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } ipl_apb_rsp_t;

   // register write strobe towards the register file
   typedef struct packed {
      logic        wr;
      logic [9:0]  idx;
      logic [15:0] data;
      logic [1:0]  strb;
   } ipl_wr_t;

   typedef enum logic {
      IPL_ST_IDLE   = 1'b0,
      IPL_ST_ACCESS = 1'b1
   } ipl_apb_st_t;

endpackage

/* File: rtl/ipl_apb_slave.sv */
// ipl_apb_slave: apb front end with one access cycle per transfer
// assumes a single apb master on clk and a combinational register read port
`timescale 1ns/100ps
`default_nettype none
`include "ipl_defines.svh"

module ipl_apb_slave (
   // clock, reset, enable
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire logic                  ce,
   // apb
   input  wire ipl_pkg::ipl_apb_req_t apbReq,
   output var  ipl_pkg::ipl_apb_rsp_t apbRsp,
   // register file side
   output logic [9:0]                 regIdx,
   input  wire logic                  regHit,
   input  wire logic [15:0]           rdData,
   output var  ipl_pkg::ipl_wr_t      wrReq
);
   import ipl_pkg::*;

   ipl_apb_st_t st_q;
   logic [15:0] rdata_q;
   logic        err_q;
   logic        setup;
   logic        access;

   assign regIdx = apbReq.paddr[`IPL_ADDR_W-1:2];
   assign setup  = ce & apbReq.psel & ~apbReq.penable;
   assign access = ce & apbReq.psel & apbReq.penable & (st_q == IPL_ST_ACCESS);

   // transfer phase
   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_q <= IPL_ST_IDLE;
      end else if (ce) begin
         case (st_q)
            IPL_ST_IDLE: begin
               if (setup) begin
                  st_q <= IPL_ST_ACCESS;
               end
            end
            IPL_ST_ACCESS: begin
               if (access || !apbReq.psel) begin
                  st_q <= IPL_ST_IDLE;
               end
            end
            default: begin
               st_q <= IPL_ST_IDLE;
            end
         endcase
      end
   end

   // read data and decode result caught in the setup cycle
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata_q <= 16'h0000;
         err_q   <= 1'b0;
      end else if (setup) begin
         rdata_q <= apbReq.pwrite ? 16'h0000 : rdData;
         err_q   <= ~regHit | (apbReq.paddr[1:0] != 2'h0);
      end
   end

   assign apbRsp.pready  = ce & (st_q == IPL_ST_ACCESS);
   assign apbRsp.prdata  = {16'h0000, rdata_q};
   assign apbRsp.pslverr = apbRsp.pready & err_q;

   assign wrReq.wr   = access & apbReq.pwrite & ~err_q;
   assign wrReq.idx  = regIdx;
   assign wrReq.data = apbReq.pwdata[15:0];
   assign wrReq.strb = apbReq.pstrb[1:0];

endmodule

`default_nettype wire

/* File: rtl/ipl_level_decode.sv */
// ipl_level_decode: turns one 2-bit level field into enable and level
// assumes the field comes straight from a register flop
`timescale 1ns/100ps
`default_nettype none

module ipl_level_decode #(
   parameter bit DEBUG_SRC = 1'b0
) (
   // field in
   input  wire logic [1:0]        field,
   // decoded source out
   output var  ipl_pkg::ipl_src_t src
);
   import ipl_pkg::*;

   // debug sources map to 1..3, all others to 0..2
   function automatic ipl_src_t decodeLevel(input logic [1:0] f, input bit dbg);
      ipl_src_t r;
      r.en    = (f != 2'h0);
      r.level = dbg ? f : f - 2'h1;
      if (!r.en) begin
         r.level = 2'h0;
      end
      return r;
   endfunction

   assign src = decodeLevel(field, DEBUG_SRC);

endmodule

`default_nettype wire

/* File: rtl/ipl_priority_regs.sv */
// ipl_priority_regs: three priority level registers for seventeen sources
// assumes an apb master on clk and arbitration logic that reads srcLevel
`timescale 1ns/100ps
`default_nettype none
`include "ipl_defines.svh"

module ipl_priority_regs (
   // clock, reset, enable
   input  wire logic                                  clk,
   input  wire logic                                  rstn,
   input  wire logic                                  ce,
   // apb
   input  wire ipl_pkg::ipl_apb_req_t                 apbReq,
   output var  ipl_pkg::ipl_apb_rsp_t                 apbRsp,
   // arbitration side
   output var  ipl_pkg::ipl_src_t [`IPL_SRC_N-1:0]    srcLevel,
   // low power wake
   input  wire logic                                  lowPower,
   input  wire logic [`IPL_SRC_N-1:0]                 srcPending,
   output logic [`IPL_SRC_N-1:0]                      wakeArmed,
   output logic                                       wakeReq
);
   import ipl_pkg::*;

   logic [15:0]           dbgReg_q;
   logic [15:0]           flashReg_q;
   logic [15:0]           portReg_q;
   logic [9:0]            regIdx;
   logic                  regHit;
   logic [15:0]           rdData;
   ipl_wr_t               wrReq;
   logic [`IPL_SRC_N-1:0] srcEn;
   logic [`IPL_SRC_N-1:0] wakeArmed_q;
   logic                  wakeReq_q;
   logic [1:0]            fieldVec [`IPL_SRC_N];

   // byte-lane merge that keeps reserved bits at zero
   function automatic logic [15:0] mergeWrite(input logic [15:0] cur,
                                              input ipl_wr_t     w,
                                              input logic [15:0] mask);
      logic [15:0] lane;
      lane = {{8{w.strb[1]}}, {8{w.strb[0]}}};
      return ((w.data & lane) | (cur & ~lane)) & mask;
   endfunction

   // true when this write targets the register at idx
   function automatic logic hitWrite(input ipl_wr_t w, input logic [9:0] idx);
      return w.wr && (w.idx == idx);
   endfunction

   ipl_apb_slave u_apb (
      .clk    (clk),
      .rstn   (rstn),
      .ce     (ce),
      .apbReq (apbReq),
      .apbRsp (apbRsp),
      .regIdx (regIdx),
      .regHit (regHit),
      .rdData (rdData),
      .wrReq  (wrReq)
   );

   // read decode
   always_comb begin
      regHit = 1'b1;
      rdData = 16'h0000;
      case (regIdx)
         `IPL_IDX_DBG:   rdData = dbgReg_q;
         `IPL_IDX_FLASH: rdData = flashReg_q;
         `IPL_IDX_PORT:  rdData = portReg_q;
         default:        regHit = 1'b0;
      endcase
   end

   // debug channel register
   always_ff @(posedge clk) begin
      if (!rstn) begin
         dbgReg_q <= `IPL_RST_DBG;
      end else if (ce && hitWrite(wrReq, `IPL_IDX_DBG)) begin
         dbgReg_q <= mergeWrite(dbgReg_q, wrReq, `IPL_WMASK_DBG);
      end
   end

   // flash, clock and pin register
   always_ff @(posedge clk) begin
      if (!rstn) begin
         flashReg_q <= `IPL_RST_FLASH;
      end else if (ce && hitWrite(wrReq, `IPL_IDX_FLASH)) begin
         flashReg_q <= mergeWrite(flashReg_q, wrReq, `IPL_WMASK_FLASH);
      end
   end

   // port and can register
   always_ff @(posedge clk) begin
      if (!rstn) begin
         portReg_q <= `IPL_RST_PORT;
      end else if (ce && hitWrite(wrReq, `IPL_IDX_PORT)) begin
         portReg_q <= mergeWrite(portReg_q, wrReq, `IPL_WMASK_PORT);
      end
   end

   // field extraction, debug sources first
   always_comb begin
      fieldVec[0]  = dbgReg_q[`IPL_POS_DBG_RX +: 2];
      fieldVec[1]  = dbgReg_q[`IPL_POS_DBG_TX +: 2];
      fieldVec[2]  = dbgReg_q[`IPL_POS_DBG_TRC +: 2];
      fieldVec[3]  = flashReg_q[`IPL_POS_FL_EMPTY +: 2];
      fieldVec[4]  = flashReg_q[`IPL_POS_FL_DONE +: 2];
      fieldVec[5]  = flashReg_q[`IPL_POS_FL_ERR +: 2];
      fieldVec[6]  = flashReg_q[`IPL_POS_PLL +: 2];
      fieldVec[7]  = flashReg_q[`IPL_POS_LVD +: 2];
      fieldVec[8]  = flashReg_q[`IPL_POS_PIN_B +: 2];
      fieldVec[9]  = flashReg_q[`IPL_POS_PIN_A +: 2];
      fieldVec[10] = portReg_q[`IPL_POS_PORT_D +: 2];
      fieldVec[11] = portReg_q[`IPL_POS_PORT_E +: 2];
      fieldVec[12] = portReg_q[`IPL_POS_PORT_F +: 2];
      fieldVec[13] = portReg_q[`IPL_POS_CAN_MSG +: 2];
      fieldVec[14] = portReg_q[`IPL_POS_CAN_WAKE +: 2];
      fieldVec[15] = portReg_q[`IPL_POS_CAN_ERR +: 2];
      fieldVec[16] = portReg_q[`IPL_POS_CAN_BOFF +: 2];
   end

   // per-source decode, shown continuously
   for (genvar i = 0; i < `IPL_SRC_N; i++) begin : g_src
      ipl_level_decode #(
         .DEBUG_SRC (i < `IPL_DBG_N)
      ) u_dec (
         .field (fieldVec[i]),
         .src   (srcLevel[i])
      );
      assign srcEn[i] = srcLevel[i].en;
   end

   // wake arming frozen while in low power
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wakeArmed_q <= '0;
      end else if (ce && !lowPower) begin
         wakeArmed_q <= srcEn;
      end
   end

   // wake request from armed pending sources
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wakeReq_q <= 1'b0;
      end else if (ce) begin
         wakeReq_q <= lowPower && |(srcPending & wakeArmed_q);
      end
   end

   assign wakeArmed = wakeArmed_q;
   assign wakeReq   = wakeReq_q;

   // checks

   reserved_dbg_zero_a:
   assert property (@(posedge clk) disable iff (!rstn)
      (dbgReg_q & ~`IPL_WMASK_DBG) == 16'h0000)
      else $error("debug register reserved bits not zero");

   reserved_other_zero_a:
   assert property (@(posedge clk) disable iff (!rstn)
      (flashReg_q[5:4] == 2'h0) && (portReg_q[1:0] == 2'h0))
      else $error("flash or port register reserved bits not zero");

   reset_clears_a:
   assert property (@(posedge clk)
      !rstn |=> (dbgReg_q == 16'h0000) && (flashReg_q == 16'h0000)
                && (portReg_q == 16'h0000) && (srcEn == '0))
      else $error("registers not cleared by reset");

   flash_write_lands_a:
   assert property (@(posedge clk) disable iff (!rstn)
      (ce && wrReq.wr && wrReq.idx == `IPL_IDX_FLASH && wrReq.strb == 2'h3)
      |=> flashReg_q == ($past(wrReq.data) & `IPL_WMASK_FLASH))
      else $error("flash register write did not land");

   port_write_lands_a:
   assert property (@(posedge clk) disable iff (!rstn)
      (ce && wrReq.wr && wrReq.idx == `IPL_IDX_PORT && wrReq.strb == 2'h3)
      |=> srcLevel[10].en == ($past(wrReq.data[15:14]) != 2'h0))
      else $error("port d level not taken from bits 15-14");

   dbg_level_map_a:
   assert property (@(posedge clk) disable iff (!rstn)
      srcLevel[0].en |-> (srcLevel[0].level == dbgReg_q[5:4])
                         && (srcLevel[0].level != 2'h0))
      else $error("debug receive level wrong");

   periph_level_map_a:
   assert property (@(posedge clk) disable iff (!rstn)
      srcLevel[3].en |-> (srcLevel[3].level == flashReg_q[15:14] - 2'h1)
                         && (srcLevel[3].level != 2'h3))
      else $error("flash empty level wrong");

   bus_off_disable_a:
   assert property (@(posedge clk) disable iff (!rstn)
      (portReg_q[3:2] == 2'h0) |-> !srcLevel[16].en)
      else $error("can bus-off enabled with zero field");

   pin_a_level_a:
   assert property (@(posedge clk) disable iff (!rstn)
      (flashReg_q[1:0] == 2'h3) |-> srcLevel[9].en && srcLevel[9].level == 2'h2)
      else $error("pin a level 3 field not level 2");

   wake_frozen_a:
   assert property (@(posedge clk) disable iff (!rstn)
      (lowPower && $past(lowPower)) |-> $stable(wakeArmed))
      else $error("wake arming changed in low power");

   wake_needs_arm_a:
   assert property (@(posedge clk) disable iff (!rstn)
      (ce && lowPower && (srcPending & wakeArmed) == '0) |=> !wakeReq)
      else $error("wake without armed pending source");

   read_back_a:
   assert property (@(posedge clk) disable iff (!rstn)
      (ce && apbReq.psel && !apbReq.penable && !apbReq.pwrite
       && apbReq.paddr == {`IPL_IDX_PORT, 2'h0})
      |=> apbRsp.prdata == {16'h0000, $past(portReg_q)})
      else $error("port register read back wrong");

endmodule

`default_nettype wire

/* File: test/ipl_apb_host_model.sv */
// ipl_apb_host_model: core side apb master issuing one transfer at a time
// assumes a zero or multi wait slave on clk
`timescale 1ns/100ps
`default_nettype none

module ipl_apb_host_model (
   // clock
   input  wire logic                  clk,
   // apb
   output var  ipl_pkg::ipl_apb_req_t apbReq,
   input  wire ipl_pkg::ipl_apb_rsp_t apbRsp,
   // status
   output logic                       timedOut
);
   import ipl_pkg::*;

   initial begin
      apbReq = '0;
      timedOut = 1'b0;
   end

   // setup, then hold until pready seen at an edge
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [15:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk);
      apbReq.psel    <= 1'b1;
      apbReq.pwrite  <= wr;
      apbReq.paddr   <= a;
      apbReq.pwdata  <= {16'h0000, d};
      apbReq.pstrb   <= wr ? s : 4'h0;
      @(posedge clk);
      apbReq.penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (apbRsp.pready === 1'b1)
            break;
      end
      if (n == 20)
         timedOut = 1'b1;
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq.psel    <= 1'b0;
      apbReq.penable <= 1'b0;
      apbReq.pwdata  <= ~apbReq.pwdata;
   endtask
endmodule
`default_nettype wire

/* File: test/ipl_priority_regs_tb.sv */
// ipl_priority_regs_tb: register, decode and wake checks through apb
// assumes ipl_apb_host_model as the core side
`timescale 1ns/100ps
`default_nettype none

module ipl_priority_regs_tb;
   import ipl_pkg::*;

   logic                  clk = 1'b0;
   logic                  rstn;
   logic                  ce;
   logic                  lowPower;
   logic [16:0]           srcPending;
   ipl_apb_req_t          apbReq;
   ipl_apb_rsp_t          apbRsp;
   ipl_src_t [16:0]       srcLevel;
   logic [16:0]           wakeArmed;
   logic                  wakeReq;
   logic                  hostTmo;
   logic [31:0]           rdat;
   logic                  rerr;
   int                    badCount = 0;
   int                    checks = 0;
   // per source register index and field low bit
   int srcIdx [17] = '{1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3, 3};
   int srcPos [17] = '{4, 2, 0, 14, 12, 10, 8, 6, 2, 0, 14, 12, 10, 8, 6, 4, 2};

   always #4 clk = ~clk;

   ipl_priority_regs i_dut (.clk(clk), .rstn(rstn), .ce(ce), .apbReq(apbReq),
      .apbRsp(apbRsp), .srcLevel(srcLevel), .lowPower(lowPower),
      .srcPending(srcPending), .wakeArmed(wakeArmed), .wakeReq(wakeReq));

   ipl_apb_host_model i_host (.clk(clk), .apbReq(apbReq), .apbRsp(apbRsp),
      .timedOut(hostTmo));

   task automatic results();
      $display("checks %0d mismatches %0d", checks, badCount);
      if (badCount == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         badCount++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus(input logic wr, input logic [11:0] a, input logic [15:0] d,
                      input logic [3:0] s);
      i_host.xfer(wr, a, d, s, rdat, rerr);
      if (hostTmo) begin
         badCount++;
         results();
      end
   endtask

   task automatic testReset();
      for (int i = 1; i < 4; i++) begin
         bus(1'b0, 12'(4 * i), 16'h0000, 4'h0);
         chk("reset value", rdat, 32'h0);
      end
      chk("levels after reset", 32'(srcLevel), 32'h0);
      $display("test reset done");
   endtask

   task automatic testReserved();
      logic [15:0] mask [3] = '{16'h003f, 16'hffcf, 16'hfffc};
      for (int i = 1; i < 4; i++) begin
         bus(1'b1, 12'(4 * i), 16'hffff, 4'h3);
         bus(1'b0, 12'(4 * i), 16'h0000, 4'h0);
         chk("masked readback", rdat, {16'h0, mask[i - 1]});
         chk("mapped error", 32'(rerr), 32'h0);
         bus(1'b1, 12'(4 * i), 16'h0000, 4'h3);
      end
      foreach (mask[j]) begin
         bus(1'b0, (j == 0) ? 12'h000 : (j == 1) ? 12'h010 : 12'h006, 16'h0, 4'h0);
         chk("unmapped error", 32'(rerr), 32'h1);
         chk("unmapped data", rdat, 32'h0);
      end
      $display("test reserved done");
   endtask

   task automatic testFields();
      logic [1:0]  v;
      logic [15:0] d;
      logic [2:0]  e;
      for (int s = 0; s < 17; s++) begin
         v = 2'(1 + s % 3);
         d = 16'(v) << srcPos[s];
         for (int r = 1; r < 4; r++)
            bus(1'b1, 12'(4 * r), (r == srcIdx[s]) ? d : 16'h0, 4'h3);
         #1;
         e = (s < 3) ? {1'b1, v} : {1'b1, v - 2'd1};
         for (int k = 0; k < 17; k++)
            chk("source level", 32'(srcLevel[k]), (k == s) ? 32'(e) : 32'h0);
         bus(1'b0, 12'(4 * srcIdx[s]), 16'h0, 4'h0);
         chk("field readback", rdat, 32'(d));
      end
      bus(1'b1, 12'h00c, 16'h0000, 4'h3);
      $display("test fields done");
   endtask

   task automatic testStrobe();
      bus(1'b1, 12'h00c, 16'hffff, 4'h1);
      #1;
      chk("bus-off after write", 32'(srcLevel[16]), 32'h6);
      chk("port d untouched", 32'(srcLevel[10]), 32'h0);
      bus(1'b1, 12'h00c, 16'h0000, 4'h0);
      bus(1'b0, 12'h00c, 16'h0, 4'h0);
      chk("low lane only", rdat, 32'h00fc);
      bus(1'b1, 12'h00c, 16'h0000, 4'h3);
      $display("test strobe done");
   endtask

   task automatic testWake();
      bus(1'b1, 12'h008, 16'h0001, 4'h3);
      @(posedge clk);
      lowPower <= 1'b1;
      repeat (2) @(posedge clk);
      // port d enabled after arming froze, then its source goes pending
      bus(1'b1, 12'h00c, 16'hc000, 4'h3);
      srcPending <= 17'h00400;
      repeat (3) @(posedge clk);
      #1;
      chk("armed set", 32'(wakeArmed), 32'h00200);
      chk("late source no wake", 32'(wakeReq), 32'h0);
      @(posedge clk);
      srcPending <= 17'h00200;
      repeat (2) @(posedge clk);
      #1;
      chk("armed source wakes", 32'(wakeReq), 32'h1);
      @(posedge clk);
      lowPower <= 1'b0;
      srcPending <= 17'h0;
      $display("test wake done");
   endtask

   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      lowPower = 1'b0;
      srcPending = 17'h0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      testReset();
      testReserved();
      testFields();
      testStrobe();
      testWake();
      results();
   end
endmodule
`default_nettype wire
